// ==== src/scm_interp.sv ====
// configuration mode entry, menu and status interpreter
`include "scm_regs.svh"

// Behaviour
// - fitted inquiry option answers ASCII zero
// - module 1 port 1 is master, any module
// - other serial ports configure own module only
// - designation, select code, banner only from master
// - master entry needs whole unit idle, unbuffered
// - master session lights leds, blocks module traffic
// - own module idle entry, leds lit, blocked
// - parallel ports never enter configuration
// - serial ports default 9600 8N1, no xon
// - control-T, C, digit 1-6 requests entry
// - master-only option refused, waits for key
// - foreign module request spooled as print job
// - entry sends identification block then menu
// - serial keys 1-9, A-D options; X exits
// - menu keys compared case sensitively
// - parallel menu shortened, keys 1 through B
// - exit resets with leds lit, no entry
// - status pages, any key next, X menu
// - exit returns to normal operation
// - master configuration port must be serial
module scm_interp
   import scm_pkg::*;
#(
   parameter int RST_CYCLES = `SCM_RST_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   input  wire scm_rx_t     i_rx,
   input  wire logic        i_inq_fitted,
   input  wire logic        i_inquiry,
   input  wire logic [23:0] i_port_busy,
   input  wire logic [5:0]  i_mod_jobs,
   input  wire logic [5:0]  i_mod_parallel,
   input  wire logic        i_out_ready,
   input  wire logic        i_opt_done,
   output scm_out_t         o_out,
   output scm_spool_t       o_spool,
   output scm_option_t      o_option,
   output logic [5:0]       o_mod_block,
   output logic [5:0]       o_mod_led,
   output logic             o_master_led,
   output logic             o_cfg_active,
   output scm_sercfg_t      o_ser_default
);

   // ====================================================
   // key decode
   function automatic logic [3:0] scm_key_opt(input logic [7:0] k, input logic par);
      logic [3:0] o;
      o = 4'h0;
      if (!par) begin
         if (k >= `SCM_DIG_1 && k <= `SCM_DIG_9)
            o = 4'(k - `SCM_DIG_0);
         else if (k >= `SCM_KEY_A && k <= `SCM_KEY_D)
            o = 4'(k - `SCM_KEY_A + 8'h0A);
      end else begin
         // key 3 unused, option 6 gone, options 7 to C move one key down
         if (k == `SCM_DIG_1 || k == 8'h32 || k == 8'h34 || k == 8'h35)
            o = 4'(k - `SCM_DIG_0);
         else if (k >= 8'h36 && k <= `SCM_DIG_9)
            o = 4'(k - `SCM_DIG_0 + 8'h01);
         else if (k == `SCM_KEY_A || k == `SCM_KEY_B)
            o = 4'(k - `SCM_KEY_A + 8'h0B);
      end
      return o;
   endfunction

   function automatic logic scm_master_only(input logic [3:0] opt);
      return opt == `SCM_OPT_DESIG || opt == `SCM_OPT_SELCODE ||
             opt == `SCM_OPT_IDMSG || opt == `SCM_OPT_IDSCHED;
   endfunction

   // ====================================================
   // state
   scm_state_t  state, next_state;
   logic [1:0]  seq, next_seq;
   logic [2:0]  src_mod, next_src_mod;
   logic [1:0]  src_port, next_src_port;
   logic [2:0]  sel_mod, next_sel_mod;
   logic [2:0]  page, next_page;
   logic [27:0] rst_cnt, next_rst_cnt;
   logic [1:0]  spool_cnt, next_spool_cnt;
   logic [7:0]  spool_dig, next_spool_dig;
   logic        inq_pend, next_inq_pend;
   scm_out_t    next_out;
   scm_spool_t  next_spool;
   scm_option_t next_option;

   logic       from_src, src_master, out_free, dig_ok, key_ok;
   logic [2:0] tmod;
   logic [3:0] key_opt;
   logic       sel_par;

   assign from_src   = i_rx.valid && i_rx.module_no == src_mod && i_rx.port_no == src_port;
   assign src_master = src_mod == `SCM_MASTER_MOD && src_port == `SCM_MASTER_PORT;
   assign out_free   = !o_out.valid || i_out_ready;
   assign dig_ok     = state == ST_IDLE && seq == 2'h2 && from_src &&
                       i_rx.data >= `SCM_DIG_1 && i_rx.data <= `SCM_DIG_6;
   assign tmod       = 3'(i_rx.data - `SCM_DIG_1);
   assign sel_par    = i_mod_parallel[sel_mod];
   assign key_ok     = from_src && out_free && !inq_pend;
   assign key_opt    = scm_key_opt(i_rx.data, sel_par);

   always_comb begin
      next_state     = state;
      next_seq       = seq;
      next_src_mod   = src_mod;
      next_src_port  = src_port;
      next_sel_mod   = sel_mod;
      next_page      = page;
      next_rst_cnt   = rst_cnt;
      next_spool_cnt = spool_cnt;
      next_spool_dig = spool_dig;
      next_inq_pend  = inq_pend || (i_inquiry && i_inq_fitted);
      next_out       = o_out;
      next_option    = o_option;
      next_spool     = '0;
      if (i_out_ready)
         next_out.valid = 1'b0;
      if (inq_pend && out_free) begin
         next_out      = '{valid: 1'b1, code: MSG_CHAR, parallel: 1'b0,
                           page: 3'h0, chr: `SCM_INQ_REPLY};
         next_inq_pend = i_inquiry && i_inq_fitted;
      end
      // replay of a refused request into the print path
      if (spool_cnt != 2'h0) begin
         next_spool.valid     = 1'b1;
         next_spool.module_no = src_mod;
         next_spool.port_no   = src_port;
         case (spool_cnt)
            2'h3:    next_spool.data = `SCM_CTRL_T;
            2'h2:    next_spool.data = `SCM_CAP_C;
            default: next_spool.data = spool_dig;
         endcase
         next_spool_cnt = 2'(spool_cnt - 2'h1);
      end
      case (state)
         ST_IDLE: begin
            if (i_rx.valid && i_rx.data == `SCM_CTRL_T && i_rx.serial) begin
               next_seq      = 2'h1;
               next_src_mod  = i_rx.module_no;
               next_src_port = i_rx.port_no;
            end else if (from_src && seq == 2'h1 && i_rx.data == `SCM_CAP_C) begin
               next_seq = 2'h2;
            end else if (dig_ok) begin
               next_seq = 2'h0;
               if (src_master) begin
                  if (i_port_busy == 24'h0 && i_mod_jobs == 6'h0) begin
                     next_state   = ST_ID;
                     next_sel_mod = tmod;
                  end
               end else if (tmod != src_mod) begin
                  next_spool_cnt = 2'h3;
                  next_spool_dig = i_rx.data;
               end else if (i_port_busy[{src_mod, 2'h0} +: 4] == 4'h0 && !i_mod_jobs[src_mod]) begin
                  next_state   = ST_ID;
                  next_sel_mod = tmod;
               end
            end else if (from_src) begin
               next_seq = 2'h0;
            end
         end
         ST_ID: begin
            if (out_free && !inq_pend) begin
               next_out = '{valid: 1'b1, code: MSG_ID, parallel: sel_par,
                            page: 3'h0, chr: 8'h00};
               next_state = ST_OPT;
               next_option.valid = 1'b0;
            end
         end
         ST_KEY: begin
            if (key_ok) begin
               if (i_rx.data == `SCM_KEY_X) begin
                  next_state   = ST_RESET;
                  next_rst_cnt = 28'h0;
               end else if (key_opt == `SCM_OPT_STATUS) begin
                  next_out   = '{valid: 1'b1, code: MSG_PAGE, parallel: sel_par,
                                 page: 3'h0, chr: 8'h00};
                  next_page  = 3'h0;
                  next_state = ST_PAGE;
               end else if (key_opt != 4'h0 && scm_master_only(key_opt) && !src_master) begin
                  next_out   = '{valid: 1'b1, code: MSG_REFUSE, parallel: sel_par,
                                 page: 3'h0, chr: 8'h00};
                  next_state = ST_REFKEY;
               end else if (key_opt != 4'h0) begin
                  next_option = '{valid: 1'b1, number: key_opt,
                                  module_no: sel_mod, master: src_master};
                  next_state  = ST_OPT;
               end else begin
                  next_out = '{valid: 1'b1, code: MSG_PROMPT, parallel: sel_par,
                               page: 3'h0, chr: 8'h00};
               end
            end
         end
         ST_PAGE: begin
            if (key_ok) begin
               if (i_rx.data == `SCM_KEY_X || page == `SCM_LAST_PAGE) begin
                  next_out   = '{valid: 1'b1, code: MSG_MENU, parallel: sel_par,
                                 page: 3'h0, chr: 8'h00};
                  next_state = ST_KEY;
               end else begin
                  next_page  = 3'(page + 3'h1);
                  next_out   = '{valid: 1'b1, code: MSG_PAGE, parallel: sel_par,
                                 page: 3'(page + 3'h1), chr: 8'h00};
               end
            end
         end
         ST_REFKEY: begin
            if (key_ok) begin
               next_out   = '{valid: 1'b1, code: MSG_MENU, parallel: sel_par,
                              page: 3'h0, chr: 8'h00};
               next_state = ST_KEY;
            end
         end
         ST_OPT: begin
            // sub-menus live outside; menu is repeated on their return
            if ((i_opt_done || !o_option.valid) && out_free && !inq_pend) begin
               next_option.valid = 1'b0;
               next_out   = '{valid: 1'b1, code: MSG_MENU, parallel: sel_par,
                              page: 3'h0, chr: 8'h00};
               next_state = ST_KEY;
            end
         end
         ST_RESET: begin
            next_rst_cnt = 28'(rst_cnt + 28'h1);
            if (rst_cnt == 28'(RST_CYCLES - 1))
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state     <= ST_IDLE;
         seq       <= 2'h0;
         src_mod   <= 3'h0;
         src_port  <= 2'h0;
         sel_mod   <= 3'h0;
         page      <= 3'h0;
         rst_cnt   <= 28'h0;
         spool_cnt <= 2'h0;
         spool_dig <= 8'h00;
         inq_pend  <= 1'b0;
         o_out     <= '0;
         o_spool   <= '0;
         o_option  <= '0;
      end else begin
         state     <= next_state;
         seq       <= next_seq;
         src_mod   <= next_src_mod;
         src_port  <= next_src_port;
         sel_mod   <= next_sel_mod;
         page      <= next_page;
         rst_cnt   <= next_rst_cnt;
         spool_cnt <= next_spool_cnt;
         spool_dig <= next_spool_dig;
         inq_pend  <= next_inq_pend;
         o_out     <= next_out;
         o_spool   <= next_spool;
         o_option  <= next_option;
      end
   end

   // ====================================================
   // indicators and traffic block
   always_comb begin
      o_cfg_active = state != ST_IDLE && state != ST_RESET;
      o_mod_block  = 6'h00;
      o_mod_led    = 6'h00;
      o_master_led = 1'b0;
      if (o_cfg_active) begin
         o_mod_block[sel_mod] = 1'b1;
         o_mod_led[sel_mod]   = 1'b1;
         o_master_led         = src_master;
      end else if (state == ST_RESET) begin
         o_mod_block  = 6'h3F;
         o_mod_led    = 6'h3F;
         o_master_led = 1'b1;
      end
   end

   assign o_ser_default = '{baud: `SCM_DEF_BAUD, bits: `SCM_DEF_BITS, stop: `SCM_DEF_STOP,
                            parity: `SCM_DEF_PARITY, xon_tx: `SCM_DEF_XON,
                            xon_rx: `SCM_DEF_XON};

   // ====================================================
   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   // replay starts two edges after the digit, not one
   sequence s_spool_three;
      o_spool.valid && o_spool.data == `SCM_CTRL_T ##1
      o_spool.valid && o_spool.data == `SCM_CAP_C ##1
      o_spool.valid && o_spool.data >= `SCM_DIG_1;
   endsequence

   sequence s_reset_lit;
      state == ST_RESET && o_mod_led == 6'h3F;
   endsequence

   chk_inq_reply: assert property (
      inq_pend && out_free |=> o_out.valid && o_out.code == MSG_CHAR && o_out.chr == `SCM_INQ_REPLY)
      else $error("inquiry reply not sent");
   chk_master_busy: assert property (
      dig_ok && src_master && (i_port_busy != 24'h0 || i_mod_jobs != 6'h0) |=> state == ST_IDLE)
      else $error("master entered while unit busy");
   chk_foreign_spool: assert property (
      dig_ok && !src_master && tmod != src_mod |=> ##1 s_spool_three)
      else $error("foreign request not spooled");
   chk_block_led: assert property (
      o_cfg_active |-> o_mod_block == o_mod_led && $onehot(o_mod_block) && o_master_led == src_master)
      else $error("session leds or block wrong");
   chk_exit_reset: assert property (
      state == ST_KEY && key_ok && i_rx.data == `SCM_KEY_X |=> s_reset_lit ##1 s_reset_lit)
      else $error("exit did not start lit reset");
   chk_reset_hold: assert property (
      state == ST_RESET && rst_cnt != 28'(RST_CYCLES - 1) |=> state == ST_RESET)
      else $error("reset ended early");
   chk_refuse_key: assert property (
      state == ST_KEY && key_ok && !src_master && key_opt != 4'h0 && scm_master_only(key_opt)
      |=> state == ST_REFKEY && o_out.code == MSG_REFUSE ##1 state == ST_REFKEY || o_out.code == MSG_MENU)
      else $error("master-only option not refused");
   chk_case_key: assert property (
      state == ST_KEY && key_ok && i_rx.data == 8'h61 |=> o_out.code == MSG_PROMPT && state == ST_KEY)
      else $error("lower case key accepted");
   chk_id_first: assert property (
      state == ST_ID && out_free && !inq_pend |=> o_out.valid && o_out.code == MSG_ID && state == ST_OPT)
      else $error("identification block not sent first");
   chk_session_lock: assert property (
      state != ST_IDLE |=> state != ST_ID && $stable(sel_mod))
      else $error("entry admitted outside idle");
   chk_parallel_port: assert property (
      state == ST_IDLE && seq == 2'h0 && i_rx.valid && !i_rx.serial |=> seq == 2'h0)
      else $error("parallel port started entry");
endmodule

// ==== src/scm_regs.svh ====
// constants of the serial configuration mode interpreter
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH
`define SCM_CTRL_T       8'h14
`define SCM_CAP_C        8'h43
`define SCM_DIG_0        8'h30
`define SCM_DIG_1        8'h31
`define SCM_DIG_6        8'h36
`define SCM_DIG_9        8'h39
`define SCM_KEY_A        8'h41
`define SCM_KEY_B        8'h42
`define SCM_KEY_D        8'h44
`define SCM_KEY_X        8'h58
`define SCM_INQ_REPLY    8'h30
`define SCM_MASTER_MOD   3'h0
`define SCM_MASTER_PORT  2'h0
`define SCM_NUM_MODS     6
`define SCM_LAST_PAGE    3'h5
`define SCM_OPT_STATUS   4'h1
`define SCM_OPT_DESIG    4'h3
`define SCM_OPT_SELCODE  4'h4
`define SCM_OPT_IDMSG    4'h9
`define SCM_OPT_IDSCHED  4'hB
`define SCM_RST_TIME_MS  5000
`define SCM_CLK_MHZ      50
`define SCM_RST_CYCLES   (`SCM_RST_TIME_MS * 1000 * `SCM_CLK_MHZ)
`define SCM_DEF_BAUD     18'h02580
`define SCM_DEF_BITS     4'h8
`define SCM_DEF_STOP     2'h1
`define SCM_DEF_PARITY   2'h0
`define SCM_DEF_XON      1'h0
`endif

// ==== src/scm_pkg.sv ====
// types of the serial configuration mode interpreter
package scm_pkg;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_ID     = 4'b0001,
      ST_KEY    = 4'b0010,
      ST_PAGE   = 4'b0011,
      ST_REFKEY = 4'b0100,
      ST_OPT    = 4'b0101,
      ST_RESET  = 4'b0110
   } scm_state_t;
   typedef enum logic [2:0] {
      MSG_NONE   = 3'b000,
      MSG_ID     = 3'b001,
      MSG_MENU   = 3'b010,
      MSG_PROMPT = 3'b011,
      MSG_REFUSE = 3'b100,
      MSG_PAGE   = 3'b101,
      MSG_CHAR   = 3'b110
   } scm_msg_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic [2:0] module_no;
      logic [1:0] port_no;
      logic       serial;
   } scm_rx_t;
   typedef struct packed {
      logic       valid;
      scm_msg_t   code;
      logic       parallel;
      logic [2:0] page;
      logic [7:0] chr;
   } scm_out_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic [2:0] module_no;
      logic [1:0] port_no;
   } scm_spool_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] number;
      logic [2:0] module_no;
      logic       master;
   } scm_option_t;
   typedef struct packed {
      logic [17:0] baud;
      logic [3:0]  bits;
      logic [1:0]  stop;
      logic [1:0]  parity;
      logic        xon_tx;
      logic        xon_rx;
   } scm_sercfg_t;
endpackage

// ==== test/scm_term_model.sv ====
// terminal model on the serial side of the interpreter
module scm_term_model
   import scm_pkg::*;
(
   input  wire logic     i_core_clk,
   input  wire scm_out_t i_out,
   input  wire logic     i_slow,
   output scm_rx_t       o_rx,
   output logic          o_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   initial begin
      o_rx = '0;
      o_ready = 1'b1;
      cnt = 2'h0;
   end
   // ==========================================
   // message sink, slow one takes one in three
   always @(negedge i_core_clk) begin
      cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      o_ready <= !i_slow || (cnt == 2'h2);
   end
   // ==========================================
   // key sender; port rate is never reprogrammed here
   task automatic send(input logic [2:0] m, input logic [1:0] p, input logic s, input logic [7:0] d);
      int n;
      n = 0;
      repeat (2) @(negedge i_core_clk);
      // a key into a busy message slot would be lost
      while (i_out.valid && n < 200) begin
         @(negedge i_core_clk);
         n++;
      end
      o_rx <= '{1'b1, d, m, p, s};
      @(negedge i_core_clk);
      o_rx.valid <= 1'b0;
      o_rx.data <= ~d;
   endtask
endmodule

// ==== test/scm_interp_tb.sv ====
// self-checking bench of the configuration mode interpreter
module scm_interp_tb
   import scm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RST = 20;
   typedef struct packed {
      logic [2:0]  m;
      logic [1:0]  p;
      logic        s;
      logic [7:0]  d;
      logic [23:0] busy;
      logic [5:0]  jobs;
      logic [5:0]  led;
      logic        ml;
      logic [1:0]  sp;
   } scm_row_t;
   logic        i_core_clk = 1'b0;
   logic        i_nrst = 1'b0;
   scm_rx_t     rx;
   logic        out_ready;
   logic        inq_fitted = 1'b0;
   logic        inquiry = 1'b0;
   logic [23:0] port_busy = 24'h000000;
   logic [5:0]  mod_jobs = 6'h00;
   logic [5:0]  mod_parallel = 6'h00;
   logic        opt_done = 1'b0;
   logic        slow = 1'b0;
   logic        exp_par = 1'b0;
   logic [2:0]  src_mod = 3'h0;
   logic [1:0]  src_port = 2'h0;
   logic [2:0]  cfg_mod = 3'h0;
   scm_out_t    o_out;
   scm_spool_t  o_spool;
   scm_option_t o_option;
   logic [5:0]  o_mod_block;
   logic [5:0]  o_mod_led;
   logic        o_master_led;
   logic        o_cfg_active;
   scm_sercfg_t o_ser_default;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   scm_out_t    msgq[$];
   logic [12:0] spq[$];
   // source, digit, busy, jobs, expected leds, master led, 1 grant 2 spool
   scm_row_t    rows [11] = '{
      {3'h0,2'h0,1'h1,8'h31,24'h000000,6'h00,6'h01,1'h1,2'h1},
      {3'h0,2'h0,1'h1,8'h36,24'h000000,6'h00,6'h20,1'h1,2'h1},
      {3'h0,2'h0,1'h1,8'h31,24'h800000,6'h00,6'h00,1'h0,2'h0},
      {3'h0,2'h0,1'h1,8'h31,24'h000000,6'h10,6'h00,1'h0,2'h0},
      {3'h2,2'h1,1'h1,8'h33,24'h000000,6'h00,6'h04,1'h0,2'h1},
      {3'h2,2'h1,1'h1,8'h33,24'h000100,6'h00,6'h00,1'h0,2'h0},
      {3'h2,2'h1,1'h1,8'h33,24'h000000,6'h04,6'h00,1'h0,2'h0},
      {3'h2,2'h1,1'h1,8'h33,24'h000001,6'h01,6'h04,1'h0,2'h1},
      {3'h2,2'h1,1'h1,8'h35,24'h000000,6'h00,6'h00,1'h0,2'h2},
      {3'h0,2'h0,1'h0,8'h31,24'h000000,6'h00,6'h00,1'h0,2'h0},
      {3'h0,2'h0,1'h1,8'h37,24'h000000,6'h00,6'h00,1'h0,2'h0}};

   scm_interp #(.RST_CYCLES(RST)) i_scm_interp (
      .i_core_clk    (i_core_clk),
      .i_nrst        (i_nrst),
      .i_rx          (rx),
      .i_inq_fitted  (inq_fitted),
      .i_inquiry     (inquiry),
      .i_port_busy   (port_busy),
      .i_mod_jobs    (mod_jobs),
      .i_mod_parallel(mod_parallel),
      .i_out_ready   (out_ready),
      .i_opt_done    (opt_done),
      .o_out         (o_out),
      .o_spool       (o_spool),
      .o_option      (o_option),
      .o_mod_block   (o_mod_block),
      .o_mod_led     (o_mod_led),
      .o_master_led  (o_master_led),
      .o_cfg_active  (o_cfg_active),
      .o_ser_default (o_ser_default)
   );
   scm_term_model i_scm_term_model (
      .i_core_clk(i_core_clk),
      .i_out     (o_out),
      .i_slow    (slow),
      .o_rx      (rx),
      .o_ready   (out_ready)
   );

   // ==========================================
   // clock, monitors and hang guard
   always #10 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (o_out.valid && out_ready)
         msgq.push_back(o_out);
      if (o_spool.valid)
         spq.push_back({o_spool.module_no, o_spool.port_no, o_spool.data});
      if (cycles == 6000) begin
         failures++;
         end_sim();
      end
   end

   // ==========================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // pairs the code with its page, character or menu variant
   task automatic chk_msg(input scm_msg_t code, input logic [7:0] val);
      scm_out_t    m;
      logic [10:0] got;
      int          n;
      n = 0;
      while (msgq.size() == 0 && n < 100) begin
         @(negedge i_core_clk);
         n++;
      end
      m = (msgq.size() != 0) ? msgq.pop_front() : '0;
      got = {m.code, 8'h00};
      if (code == MSG_PAGE)
         got[7:0] = {5'h00, m.page};
      if (code == MSG_CHAR)
         got[7:0] = m.chr;
      if (code == MSG_MENU)
         got[7:0] = {7'h00, m.parallel};
      chk(got, {code, val});
   endtask
   task automatic key(input logic [7:0] k);
      i_scm_term_model.send(src_mod, src_port, 1'b1, k);
   endtask
   task automatic req(input logic [2:0] m, input logic [1:0] p, input logic s, input logic [7:0] d);
      i_scm_term_model.send(m, p, s, 8'h14);
      i_scm_term_model.send(m, p, s, 8'h43);
      i_scm_term_model.send(m, p, s, d);
      repeat (5) @(negedge i_core_clk);
   endtask
   task automatic opt(input logic [7:0] k, input logic [3:0] n);
      key(k);
      repeat (3) @(negedge i_core_clk);
      chk({o_option.valid, o_option.number, o_option.module_no, o_option.master},
          {1'b1, n, cfg_mod, src_mod == 3'h0 && src_port == 2'h0});
      opt_done = 1'b1;
      @(negedge i_core_clk);
      opt_done = 1'b0;
      chk_msg(MSG_MENU, {7'h00, exp_par});
   endtask
   task automatic quit();
      key(8'h58);
      repeat (3) @(negedge i_core_clk);
      chk({o_mod_led, o_mod_block}, 12'hFFF);
      repeat (RST + 5) @(negedge i_core_clk);
      chk({o_cfg_active, o_mod_led, o_mod_block}, 13'h0000);
      msgq.delete();
   endtask
   task automatic pulse_inq();
      inquiry = 1'b1;
      @(negedge i_core_clk);
      inquiry = 1'b0;
   endtask

   // ==========================================
   // main sequence
   initial begin
      int       i;
      scm_row_t r;
      repeat (10) @(negedge i_core_clk);
      chk({o_out.valid, o_spool.valid, o_option.valid, o_mod_led, o_cfg_active}, 10'h000);
      i_nrst = 1'b1;
      chk(o_ser_default, {18'h02580, 4'h8, 2'h1, 2'h0, 1'h0, 1'h0});
      foreach (rows[i]) begin
         r = rows[i];
         port_busy = r.busy;
         mod_jobs = r.jobs;
         src_mod = r.m;
         src_port = r.p;
         cfg_mod = r.d[2:0] - 3'h1;
         spq.delete();
         req(r.m, r.p, r.s, r.d);
         chk(o_cfg_active, r.sp == 2'h1);
         chk({o_mod_led, o_mod_block, o_master_led}, {r.led, r.led, r.ml});
         chk(spq.size(), (r.sp == 2'h2) ? 3 : 0);
         if (r.sp == 2'h2) begin
            chk({spq[0][7:0], spq[1][7:0], spq[2][7:0]}, {8'h14, 8'h43, r.d});
            chk({spq[0][12:8], spq[2][12:8]}, {r.m, r.p, r.m, r.p});
         end
         if (r.sp == 2'h1) begin
            chk_msg(MSG_ID, 8'h00);
            chk_msg(MSG_MENU, 8'h00);
            quit();
         end
         msgq.delete();
      end
      port_busy = 24'h000000;
      mod_jobs = 6'h00;
      src_mod = 3'h0;
      src_port = 2'h0;
      cfg_mod = 3'h0;
      req(3'h0, 2'h0, 1'h1, 8'h31);
      chk_msg(MSG_ID, 8'h00);
      chk_msg(MSG_MENU, 8'h00);
      slow = 1'b1;
      key(8'h31);
      for (i = 0; i < 6; i++) begin
         chk_msg(MSG_PAGE, i[7:0]);
         key(8'h51);
      end
      chk_msg(MSG_MENU, 8'h00);
      key(8'h31);
      chk_msg(MSG_PAGE, 8'h00);
      key(8'h58);
      chk_msg(MSG_MENU, 8'h00);
      slow = 1'b0;
      key(8'h61);
      chk_msg(MSG_PROMPT, 8'h00);
      key(8'h3F);
      chk_msg(MSG_PROMPT, 8'h00);
      for (i = 0; i < 12; i++)
         opt((i < 8) ? 8'h32 + i[7:0] : 8'h39 + i[7:0], i[3:0] + 4'h2);
      req(3'h2, 2'h1, 1'h1, 8'h33);
      chk(o_mod_led, 6'h01);
      opt_done = 1'b1;
      @(negedge i_core_clk);
      opt_done = 1'b0;
      key(8'h58);
      repeat (3) @(negedge i_core_clk);
      chk({o_mod_led, o_mod_block}, 12'hFFF);
      req(3'h0, 2'h0, 1'h1, 8'h32);
      repeat (RST) @(negedge i_core_clk);
      chk({o_cfg_active, o_mod_led}, 7'h00);
      msgq.delete();
      src_mod = 3'h2;
      src_port = 2'h1;
      cfg_mod = 3'h2;
      req(3'h2, 2'h1, 1'h1, 8'h33);
      chk_msg(MSG_ID, 8'h00);
      chk_msg(MSG_MENU, 8'h00);
      for (i = 0; i < 4; i++) begin
         key(i == 0 ? 8'h33 : i == 1 ? 8'h34 : i == 2 ? 8'h39 : 8'h42);
         chk_msg(MSG_REFUSE, 8'h00);
         key(8'h20);
         chk_msg(MSG_MENU, 8'h00);
      end
      opt(8'h36, 4'h6);
      quit();
      // parallel module: shortened menu, renumbered keys
      mod_parallel = 6'h08;
      src_mod = 3'h0;
      src_port = 2'h0;
      cfg_mod = 3'h3;
      exp_par = 1'b1;
      req(3'h0, 2'h0, 1'h1, 8'h34);
      chk_msg(MSG_ID, 8'h00);
      chk_msg(MSG_MENU, 8'h01);
      opt(8'h36, 4'h7);
      opt(8'h41, 4'hB);
      key(8'h43);
      chk_msg(MSG_PROMPT, 8'h00);
      quit();
      exp_par = 1'b0;
      pulse_inq();
      repeat (5) @(negedge i_core_clk);
      chk(msgq.size(), 0);
      inq_fitted = 1'b1;
      pulse_inq();
      chk_msg(MSG_CHAR, 8'h30);
      // reset in mid-session drops everything
      req(3'h0, 2'h0, 1'h1, 8'h31);
      i_nrst = 1'b0;
      @(negedge i_core_clk);
      chk({o_cfg_active, o_mod_led, o_master_led, o_option.valid}, 9'h000);
      i_nrst = 1'b1;
      repeat (2) @(negedge i_core_clk);
      chk({o_cfg_active, o_out.valid, o_spool.valid, o_option.valid}, 4'h0);
      msgq.delete();
      req(3'h0, 2'h0, 1'h1, 8'h31);
      chk_msg(MSG_ID, 8'h00);
      chk_msg(MSG_MENU, 8'h00);
      end_sim();
   end
endmodule
